// file: acref_pkg.sv
package acref_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_MASKED   = 8'h00;
   localparam logic [7:0] OFS_RAW      = 8'h04;
   localparam logic [7:0] OFS_ENABLE   = 8'h08;
   localparam logic [7:0] OFS_REFCTL   = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h20;
   localparam logic [7:0] OFS_CMPCTL   = 8'h24;
   localparam logic [31:0] BASE_ADDR   = 32'h4003C000;
   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int          IRQ_BIT     = 0;
   localparam int          LADDER_PWR  = 9;
   localparam int          LADDER_RNG  = 8;
   localparam int          COMPARATOR_OUTPUT_VALUE_BIT    = 1;
   localparam logic [31:0] RST_WORD    = 32'h00000000;
   localparam logic [1:0]  SRC_INTREF  = 2'h2;
   localparam logic [1:0]  SENSE_LEVEL = 2'h0;
   localparam logic [1:0]  SENSE_FALL  = 2'h1;
   localparam logic [1:0]  SENSE_RISE  = 2'h2;
   localparam logic [1:0]  SENSE_BOTH  = 2'h3;
   localparam logic [5:0]  RATIO_OFS32 = 6'h08;
   localparam logic [5:0]  DEN_RNG0    = 6'h20;
   localparam logic [5:0]  DEN_RNG1    = 6'h18;

   // -------------------------------------------------------------
   // analog control carrier
   // -------------------------------------------------------------
   typedef struct packed {
      logic       ladder_power;
      logic       ladder_range_select;
      logic [3:0] ladder_tap;
      logic [1:0] positive_input_source;
   } acref_analog_t;

   typedef struct packed {
      logic [5:0] num;
      logic [5:0] den;
   } acref_ratio_t;
endpackage

// file: acref_regs.sv
`timescale 1ns/1ns
module acref_regs (
   // clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   reset_i,
   input  wire logic                   clk_en_i,
   // apb slave
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [31:0]            paddr_i,
   input  wire logic [31:0]            pwdata_i,
   output logic      [31:0]            prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   // comparator
   input  wire logic                   comparator_out_i,
   output acref_pkg::acref_analog_t    analog_o,
   output acref_pkg::acref_ratio_t     ref_ratio_o,
   output logic                        irq_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic        comparator_output_value;
   logic        prev_value;
   logic        comparator_irq_bit;
   logic        irq_enable;
   logic        ladder_power;
   logic        ladder_range_select;
   logic [3:0]  ladder_tap;
   logic [1:0]  positive_input_source;
   logic [1:0]  interrupt_sense_select;
   logic        interrupt_level_value;
   logic        adc_trigger_enable;
   logic        trigger_level_value;
   logic [1:0]  trigger_sense_select;
   logic        event_hit;
   logic [2:0]  sync_fill;
   logic        access;
   logic        wr;
   logic        hit;
   logic [7:0]  ofs;
   logic [31:0] next_rdata;

   assign access = psel_i && penable_i && !pready_o;
   // write lands on the edge where the master sees pready
   assign wr     = psel_i && penable_i && pready_o && pwrite_i;
   assign ofs    = paddr_i[7:0];
   assign hit    = (paddr_i[31:8] == acref_pkg::BASE_ADDR[31:8]) && (ofs[1:0] == 2'h0);

   // ----------------------------------------------------------------
   // synchroniser
   // ----------------------------------------------------------------
   acref_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .clk_en_i  (clk_en_i),
      .async_i   (comparator_out_i),
      .sync_o    (comparator_output_value)
   );

   // holds events off until the pipe carries real samples
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sync_fill <= 3'h0;
      end else if (clk_en_i) begin
         sync_fill <= {sync_fill[1:0], 1'b1};
      end
   end

   // ----------------------------------------------------------------
   // interrupt condition
   // ----------------------------------------------------------------
   always_comb begin
      event_hit = 1'b0;
      if (sync_fill[2]) begin
         case (interrupt_sense_select)
            acref_pkg::SENSE_LEVEL: event_hit = comparator_output_value == interrupt_level_value;
            acref_pkg::SENSE_FALL:  event_hit = prev_value && !comparator_output_value;
            acref_pkg::SENSE_RISE:  event_hit = !prev_value && comparator_output_value;
            acref_pkg::SENSE_BOTH:  event_hit = prev_value != comparator_output_value;
            default:                event_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         prev_value <= 1'b0;
      end else if (clk_en_i) begin
         prev_value <= comparator_output_value;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         comparator_irq_bit <= 1'b0;
      end else if (clk_en_i) begin
         if (event_hit) begin
            comparator_irq_bit <= 1'b1;
         end else if (wr && hit && ofs == acref_pkg::OFS_MASKED
                      && pwdata_i[acref_pkg::IRQ_BIT]) begin
            comparator_irq_bit <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else if (clk_en_i) begin
         irq_o <= comparator_irq_bit && irq_enable;
      end
   end

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         irq_enable             <= 1'b0;
         ladder_power           <= 1'b0;
         ladder_range_select    <= 1'b0;
         ladder_tap             <= 4'h0;
         positive_input_source  <= 2'h0;
         interrupt_sense_select <= 2'h0;
         interrupt_level_value  <= 1'b0;
         adc_trigger_enable     <= 1'b0;
         trigger_level_value    <= 1'b0;
         trigger_sense_select   <= 2'h0;
      end else if (clk_en_i && wr && hit) begin
         case (ofs)
            acref_pkg::OFS_ENABLE: begin
               irq_enable <= pwdata_i[acref_pkg::IRQ_BIT];
            end
            acref_pkg::OFS_REFCTL: begin
               ladder_power        <= pwdata_i[acref_pkg::LADDER_PWR];
               ladder_range_select <= pwdata_i[acref_pkg::LADDER_RNG];
               ladder_tap          <= pwdata_i[3:0];
            end
            acref_pkg::OFS_CMPCTL: begin
               adc_trigger_enable     <= pwdata_i[11];
               positive_input_source  <= pwdata_i[10:9];
               trigger_level_value    <= pwdata_i[7];
               trigger_sense_select   <= pwdata_i[6:5];
               interrupt_level_value  <= pwdata_i[4];
               interrupt_sense_select <= pwdata_i[3:2];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // analog outputs and reference ratio
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         analog_o    <= '0;
         ref_ratio_o <= '0;
      end else if (clk_en_i) begin
         analog_o.ladder_power          <= ladder_power;
         analog_o.ladder_range_select   <= ladder_range_select;
         analog_o.ladder_tap            <= ladder_tap;
         analog_o.positive_input_source <= positive_input_source;
         if (!ladder_power) begin
            ref_ratio_o.num <= 6'h00;
            ref_ratio_o.den <= acref_pkg::DEN_RNG0;
         end else if (!ladder_range_select) begin
            ref_ratio_o.num <= {2'h0, ladder_tap} + acref_pkg::RATIO_OFS32;
            ref_ratio_o.den <= acref_pkg::DEN_RNG0;
         end else begin
            ref_ratio_o.num <= {2'h0, ladder_tap};
            ref_ratio_o.den <= acref_pkg::DEN_RNG1;
         end
      end
   end

   // ----------------------------------------------------------------
   // apb read and handshake
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = acref_pkg::RST_WORD;
      if (hit) begin
         case (ofs)
            acref_pkg::OFS_MASKED: next_rdata[0] = comparator_irq_bit && irq_enable;
            acref_pkg::OFS_RAW:    next_rdata[0] = comparator_irq_bit;
            acref_pkg::OFS_ENABLE: next_rdata[0] = irq_enable;
            acref_pkg::OFS_REFCTL: next_rdata = {22'h0, ladder_power, ladder_range_select,
                                                 4'h0, ladder_tap};
            acref_pkg::OFS_STATUS: next_rdata[1] = comparator_output_value;
            acref_pkg::OFS_CMPCTL: next_rdata = {20'h0, adc_trigger_enable,
                                                 positive_input_source, 1'b0,
                                                 trigger_level_value, trigger_sense_select,
                                                 interrupt_level_value,
                                                 interrupt_sense_select, 2'h0};
            default:               next_rdata = acref_pkg::RST_WORD;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else if (clk_en_i) begin
         pready_o  <= access;
         pslverr_o <= 1'b0;
         if (access && !pwrite_i) begin
            prdata_o <= next_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_raw_set_event: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && event_hit |=> comparator_irq_bit)
      else $error("raw status not set after event");
   a_irq_gate_enable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      irq_o |-> $past(irq_enable))
      else $error("irq raised while disabled");
   a_w1c_clears_bit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr && hit && ofs == 8'h00 && pwdata_i[0] && !event_hit
      |=> !comparator_irq_bit)
      else $error("write one did not clear");
   a_ladder_off_ground: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && !ladder_power |=> ref_ratio_o.num == 6'h00)
      else $error("reference not ground while unpowered");
   a_range0_ratio: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && ladder_power && !ladder_range_select
      |=> ref_ratio_o.num == $past(ladder_tap) + 6'h08 && ref_ratio_o.den == 6'h20)
      else $error("range zero ratio wrong");
   a_range1_ratio: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && ladder_power && ladder_range_select
      |=> ref_ratio_o.num == $past(ladder_tap) && ref_ratio_o.den == 6'h18)
      else $error("range one ratio wrong");
   a_pready_follows: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && access |=> pready_o ##1 !pready_o)
      else $error("apb answer timing wrong");
   a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      pready_o && !pwrite_i && paddr_i[7:0] == 8'h10 |-> prdata_o[31:10] == 22'h0)
      else $error("reserved bits not zero");
   a_status_value: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && access && !pwrite_i && hit && ofs == 8'h20
      |=> prdata_o[1] == $past(comparator_output_value))
      else $error("status bit wrong");
   a_power_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr && hit && ofs == 8'h10 |=> ladder_power == $past(pwdata_i[9]))
      else $error("ladder power not written");
   c_irq_raised: cover property (@(posedge ref_clk_i) disable iff (reset_i) irq_o);
   c_irq_cleared: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      comparator_irq_bit ##1 !comparator_irq_bit);
   c_range1_on: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      ladder_power && ladder_range_select);
   c_set_and_clear: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      event_hit && wr && ofs == 8'h00);
   a_enable_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr && hit && ofs == 8'h08 |=> irq_enable == $past(pwdata_i[0]))
      else $error("interrupt enable not written");
   a_ladder_fields: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr && hit && ofs == 8'h10
      |=> ladder_range_select == $past(pwdata_i[8]) && ladder_tap == $past(pwdata_i[3:0]))
      else $error("ladder range or tap not written");
   a_source_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr && hit && ofs == 8'h24 |=> positive_input_source == $past(pwdata_i[10:9]))
      else $error("input source not written");
   a_level_sense: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && sync_fill[2] && interrupt_sense_select == 2'h0
      && comparator_output_value == interrupt_level_value |=> comparator_irq_bit)
      else $error("level sense did not set raw status");
   a_raw_read_only: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr && hit && ofs == 8'h04 && !event_hit
      |=> comparator_irq_bit == $past(comparator_irq_bit))
      else $error("raw status changed by a write");
   a_power_reset_off: assert property (@(posedge ref_clk_i)
      reset_i |=> !ladder_power && !analog_o.ladder_power)
      else $error("ladder powered after reset");
   c_clock_frozen: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      !clk_en_i ##1 !clk_en_i);
endmodule

// file: acref_regs_test.sv
`timescale 1ns/1ns
module acref_regs_test;
   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   logic                     ref_clk_i;
   logic                     reset_i;
   logic                     clk_en_i;
   logic                     psel_i;
   logic                     penable_i;
   logic                     pwrite_i;
   logic [31:0]              paddr_i;
   logic [31:0]              pwdata_i;
   logic [31:0]              prdata_o;
   logic                     pready_o;
   logic                     pslverr_o;
   logic                     comparator_out_i;
   acref_pkg::acref_analog_t analog_o;
   acref_pkg::acref_ratio_t  ref_ratio_o;
   logic                     irq_o;
   logic [31:0]              rd;
   logic [3:0]               taps [3] = '{4'h0, 4'h5, 4'hF};
   int                       mismatches;
   int                       check_count;

   acref_regs i_dut (
      .ref_clk_i        (ref_clk_i),
      .reset_i          (reset_i),
      .clk_en_i         (clk_en_i),
      .psel_i           (psel_i),
      .penable_i        (penable_i),
      .pwrite_i         (pwrite_i),
      .paddr_i          (paddr_i),
      .pwdata_i         (pwdata_i),
      .prdata_o         (prdata_o),
      .pready_o         (pready_o),
      .pslverr_o        (pslverr_o),
      .comparator_out_i (comparator_out_i),
      .analog_o         (analog_o),
      .ref_ratio_o      (ref_ratio_o),
      .irq_o            (irq_o)
   );

   always #4 ref_clk_i = ~ref_clk_i;

   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      @(posedge ref_clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         mismatches++;
         $display("Error at %0t: no ready", $time);
         tally_and_finish;
      end
      rd = prdata_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   function automatic logic [31:0] adr(input logic [7:0] o);
      return acref_pkg::BASE_ADDR + {24'h000000, o};
   endfunction

   task wr(input logic [7:0] o, input logic [31:0] d);
      apb(1'b1, adr(o), d);
   endtask

   task rr(input logic [7:0] o, input logic [31:0] exp);
      apb(1'b0, adr(o), 32'h00000000);
      check(rd, exp);
   endtask

   task comp(input logic v);
      @(posedge ref_clk_i);
      comparator_out_i <= v;
      repeat (6) @(posedge ref_clk_i);
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      logic [5:0] num;
      logic [5:0] den;
      ref_clk_i        = 1'b0;
      reset_i          = 1'b1;
      clk_en_i         = 1'b1;
      psel_i           = 1'b0;
      penable_i        = 1'b0;
      pwrite_i         = 1'b0;
      paddr_i          = 32'h00000000;
      pwdata_i         = 32'h00000000;
      comparator_out_i = 1'b1;
      mismatches       = 0;
      check_count      = 0;
      repeat (6) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rr(acref_pkg::OFS_MASKED, 32'h00000000);
      rr(acref_pkg::OFS_RAW, 32'h00000000);
      rr(acref_pkg::OFS_ENABLE, 32'h00000000);
      rr(acref_pkg::OFS_REFCTL, 32'h00000000);
      rr(acref_pkg::OFS_STATUS, 32'h00000002);
      rr(acref_pkg::OFS_CMPCTL, 32'h00000000);
      check({24'h000000, analog_o}, 32'h00000000);
      wr(8'h0C, 32'hFFFFFFFF);
      rr(8'h0C, 32'h00000000);
      apb(1'b1, 32'h4003D010, 32'h0000030F);
      check(rd, 32'h00000000);
      rr(acref_pkg::OFS_REFCTL, 32'h00000000);
      wr(acref_pkg::OFS_REFCTL, 32'hFFFFFFFF);
      rr(acref_pkg::OFS_REFCTL, 32'h0000030F);
      wr(acref_pkg::OFS_CMPCTL, 32'hFFFFFFFF);
      rr(acref_pkg::OFS_CMPCTL, 32'h00000EFC);
      wr(acref_pkg::OFS_ENABLE, 32'hFFFFFFFF);
      rr(acref_pkg::OFS_ENABLE, 32'h00000001);
      wr(acref_pkg::OFS_CMPCTL, 32'h00000000);
      wr(acref_pkg::OFS_ENABLE, 32'h00000000);
      wr(acref_pkg::OFS_RAW, 32'hFFFFFFFF);
      rr(acref_pkg::OFS_RAW, 32'h00000000);
      wr(acref_pkg::OFS_STATUS, 32'h00000000);
      rr(acref_pkg::OFS_STATUS, 32'h00000002);
      // ladder range and tap sweep
      for (int r = 0; r < 2; r++) begin
         foreach (taps[i]) begin
            wr(acref_pkg::OFS_REFCTL, {22'h0, 1'b1, r[0], 4'h0, taps[i]});
            repeat (2) @(posedge ref_clk_i);
            num = (r == 1) ? {2'h0, taps[i]} : {2'h0, taps[i]} + 6'h08;
            den = (r == 1) ? 6'h18 : 6'h20;
            check({20'h00000, ref_ratio_o}, {20'h00000, num, den});
            check({24'h000000, analog_o}, {24'h000000, 1'b1, r[0], taps[i], 2'h0});
         end
      end
      wr(acref_pkg::OFS_REFCTL, 32'h0000010F);
      repeat (2) @(posedge ref_clk_i);
      check({20'h00000, ref_ratio_o}, 32'h00000020);
      check({24'h000000, analog_o}, 32'h0000007C);
      wr(acref_pkg::OFS_REFCTL, 32'h0000030C);
      wr(acref_pkg::OFS_CMPCTL, 32'h0000040C);
      repeat (2) @(posedge ref_clk_i);
      check({24'h000000, analog_o}, 32'h000000F2);
      check({20'h00000, ref_ratio_o}, 32'h00000318);
      // level sense, enable gating and clearing
      wr(acref_pkg::OFS_CMPCTL, 32'h00000010);
      repeat (4) @(posedge ref_clk_i);
      rr(acref_pkg::OFS_RAW, 32'h00000001);
      rr(acref_pkg::OFS_MASKED, 32'h00000000);
      check({31'h0, irq_o}, 32'h00000000);
      wr(acref_pkg::OFS_ENABLE, 32'h00000001);
      repeat (2) @(posedge ref_clk_i);
      check({31'h0, irq_o}, 32'h00000001);
      rr(acref_pkg::OFS_MASKED, 32'h00000001);
      wr(acref_pkg::OFS_MASKED, 32'h00000001);
      rr(acref_pkg::OFS_RAW, 32'h00000001);
      wr(acref_pkg::OFS_CMPCTL, 32'h00000008);
      wr(acref_pkg::OFS_MASKED, 32'h00000000);
      rr(acref_pkg::OFS_MASKED, 32'h00000001);
      wr(acref_pkg::OFS_MASKED, 32'h00000001);
      rr(acref_pkg::OFS_RAW, 32'h00000000);
      check({31'h0, irq_o}, 32'h00000000);
      // edge sense codes
      comp(1'b0);
      rr(acref_pkg::OFS_RAW, 32'h00000000);
      rr(acref_pkg::OFS_STATUS, 32'h00000000);
      comp(1'b1);
      rr(acref_pkg::OFS_RAW, 32'h00000001);
      check({31'h0, irq_o}, 32'h00000001);
      wr(acref_pkg::OFS_MASKED, 32'h00000001);
      wr(acref_pkg::OFS_CMPCTL, 32'h00000004);
      comp(1'b0);
      rr(acref_pkg::OFS_RAW, 32'h00000001);
      wr(acref_pkg::OFS_MASKED, 32'h00000001);
      wr(acref_pkg::OFS_CMPCTL, 32'h0000000C);
      comp(1'b1);
      rr(acref_pkg::OFS_RAW, 32'h00000001);
      // clock enable low freezes all state
      wr(acref_pkg::OFS_MASKED, 32'h00000001);
      repeat (2) @(posedge ref_clk_i);
      clk_en_i <= 1'b0;
      comp(1'b0);
      check({31'h0, irq_o}, 32'h00000000);
      clk_en_i <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      rr(acref_pkg::OFS_RAW, 32'h00000001);
      tally_and_finish;
   end
endmodule

// file: acref_sync.sv
`timescale 1ns/1ns
module acref_sync (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   input  wire logic clk_en_i,
   // data
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta;

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end else if (clk_en_i) begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule
